// File: spp_parallel_port_registers.sv
`timescale 1ns/100ps
`default_nettype none
module spp_parallel_port_registers
    import spp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // mode from the configuration logic
    input wire logic [1:0] port_mode,
    // host strobes and data
    input wire logic [1:0] host_addr,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_rdata_oe_n,
    // epp engine: peripheral stall and time-out abort
    input wire logic epp_cycle_stalled,
    output logic epp_timeout_abort,
    // printer data lines
    input wire logic [7:0] printer_data_lines_in,
    output logic [7:0] printer_data_lines_out,
    output logic printer_data_lines_oe_n,
    // handshake outputs and their sensed pin levels
    output logic printer_strobe_n,
    output logic line_feed_n,
    output logic printer_init_n,
    output logic select_in_n,
    input wire logic printer_strobe_n_in,
    input wire logic line_feed_n_in,
    input wire logic printer_init_n_in,
    input wire logic select_in_n_in,
    // printer status inputs
    input wire logic printer_fault_n,
    input wire logic printer_selected,
    input wire logic paper_out,
    input wire logic printer_ack_n,
    input wire logic printer_not_ready_pin,
    // interrupt request, tri-state style, driven high or low while enabled in compat, ext and epp modes; floated in the other mode
    output logic port_irq,
    output logic port_irq_oe_n
);

    function automatic logic is_epp(input logic [1:0] m);
        is_epp = (m == SPP_MODE_EPP);
    endfunction

    // host strobe edge detection
    logic rd_n_q, rd_n_d, wr_n_q, wr_n_d;
    logic rd_start, wr_start;
    // register state
    logic [7:0] data_q, data_d;
    logic [5:0] ctl_q, ctl_d;
    logic tout_q, tout_d;
    logic irq_stat_n_q, irq_stat_n_d;
    logic ack_n_q, ack_n_d;
    logic [1:0] mode_q, mode_d;
    logic [SPP_TOUT_W-1:0] tcnt_q, tcnt_d;
    logic tout_evt_q, tout_evt_d;
    // outputs registered
    logic [7:0] rdata_q, rdata_d;
    logic rdata_oe_n_q, rdata_oe_n_d;
    logic irq_q, irq_d, irq_oe_n_q, irq_oe_n_d;
    logic pd_oe_n_q, pd_oe_n_d;
    logic [7:0] status_v, control_v;
    logic ack_rise;

    assign rd_start = rd_n_q & ~host_rd_n;
    assign wr_start = wr_n_q & ~host_wr_n;
    assign ack_rise = ~ack_n_q & printer_ack_n;

    // read views of status and control
    always_comb begin
        status_v = 8'h00;
        status_v[SPP_ST_TOUT] = is_epp(port_mode) ? tout_q : 1'b1;
        status_v[SPP_ST_RSVD] = 1'b1;
        status_v[SPP_ST_IRQ] = (port_mode == SPP_MODE_EXT) ? irq_stat_n_q : 1'b1;
        status_v[SPP_ST_FAULT] = printer_fault_n;
        status_v[SPP_ST_SEL] = printer_selected;
        status_v[SPP_ST_PAPER] = paper_out;
        status_v[SPP_ST_ACK] = printer_ack_n;
        status_v[SPP_ST_READY] = ~printer_not_ready_pin;
        // pin levels win so an externally forced line is visible
        control_v = {SPP_CTL_HI_BITS, 1'b1, ctl_q[SPP_CT_IEN], ~select_in_n_in,
            printer_init_n_in, ~line_feed_n_in, ~printer_strobe_n_in};
        control_v[SPP_CT_DIR] = is_epp(port_mode) ? ctl_q[SPP_CT_DIR] : 1'b1;
    end

    // host interface and read data path
    always_comb begin
        rd_n_d = host_rd_n;
        wr_n_d = host_wr_n;
        rdata_d = rdata_q;
        // offset 3 is left undriven so another decoder may own it
        rdata_oe_n_d = host_rd_n | (host_addr == SPP_OFS_NONE);
        if (rd_start) begin
            unique case (host_addr)
                SPP_OFS_DATA: rdata_d = (port_mode == SPP_MODE_EXT && ctl_q[SPP_CT_DIR])
                    ? printer_data_lines_in : data_q;
                SPP_OFS_STATUS: rdata_d = status_v;
                SPP_OFS_CONTROL: rdata_d = control_v;
                SPP_OFS_NONE: rdata_d = rdata_q;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rdata_q <= 8'h00;
            rdata_oe_n_q <= 1'b1;
        end else begin
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            rdata_q <= rdata_d;
            rdata_oe_n_q <= rdata_oe_n_d;
        end
    end

    // data and control latches; status writes fall through untouched
    always_comb begin
        data_d = data_q;
        ctl_d = ctl_q;
        if (wr_start && host_addr == SPP_OFS_DATA)
            data_d = host_wdata;
        if (wr_start && host_addr == SPP_OFS_CONTROL)
            ctl_d = host_wdata[5:0];
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            data_q <= SPP_DATA_RST;
            ctl_q <= SPP_CTL_RST;
        end else begin
            data_q <= data_d;
            ctl_q <= ctl_d;
        end
    end

    // epp time-out watchdog and the status flags it feeds
    always_comb begin
        mode_d = port_mode;
        ack_n_d = printer_ack_n;
        tcnt_d = tcnt_q;
        tout_evt_d = 1'b0;
        if (!is_epp(port_mode) || !epp_cycle_stalled)
            tcnt_d = '0;
        else if (tcnt_q == SPP_TOUT_W'(SPP_TOUT_CYC - 1)) begin
            tcnt_d = '0;
            tout_evt_d = 1'b1;
        end else
            tcnt_d = tcnt_q + 1'b1;
        // set wins over the read clear so no time-out is lost
        tout_d = tout_q;
        if (is_epp(port_mode) && !is_epp(mode_q))
            tout_d = 1'b0;
        else if (tout_evt_q)
            tout_d = 1'b1;
        else if (rd_start && host_addr == SPP_OFS_STATUS)
            tout_d = 1'b0;
        // low latch also wins over the read restore
        irq_stat_n_d = irq_stat_n_q;
        if (port_mode != SPP_MODE_EXT)
            irq_stat_n_d = 1'b1;
        else if (ctl_q[SPP_CT_IEN] && ack_rise)
            irq_stat_n_d = 1'b0;
        else if (rd_start && host_addr == SPP_OFS_STATUS)
            irq_stat_n_d = 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_q <= SPP_MODE_COMPAT;
            ack_n_q <= 1'b1;
            tcnt_q <= '0;
            tout_evt_q <= 1'b0;
            tout_q <= 1'b1;
            irq_stat_n_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            ack_n_q <= ack_n_d;
            tcnt_q <= tcnt_d;
            tout_evt_q <= tout_evt_d;
            tout_q <= tout_d;
            irq_stat_n_q <= irq_stat_n_d;
        end
    end

    // interrupt routing and data line direction
    always_comb begin
        irq_oe_n_d = 1'b1;
        irq_d = 1'b0;
        if (ctl_q[SPP_CT_IEN]) begin
            unique case (port_mode)
                SPP_MODE_COMPAT: begin
                    irq_oe_n_d = 1'b0;
                    irq_d = printer_ack_n;
                end
                SPP_MODE_EXT: begin
                    irq_oe_n_d = 1'b0;
                    irq_d = ~irq_stat_n_d;
                end
                SPP_MODE_EPP: begin
                    irq_oe_n_d = 1'b0;
                    irq_d = printer_ack_n | tout_evt_q;
                end
                // ecp irq belongs to other logic; stays floated here
                SPP_MODE_OTHER: irq_oe_n_d = 1'b1;
            endcase
        end
        // only extended mode with direction set turns the lines around
        pd_oe_n_d = (port_mode == SPP_MODE_EXT) && ctl_q[SPP_CT_DIR];
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_q <= 1'b0;
            irq_oe_n_q <= 1'b1;
            pd_oe_n_q <= 1'b1;
        end else begin
            irq_q <= irq_d;
            irq_oe_n_q <= irq_oe_n_d;
            pd_oe_n_q <= pd_oe_n_d;
        end
    end

    assign host_rdata = rdata_q;
    assign host_rdata_oe_n = rdata_oe_n_q;
    assign epp_timeout_abort = tout_evt_q;
    assign printer_data_lines_out = data_q;
    assign printer_data_lines_oe_n = pd_oe_n_q;
    assign printer_strobe_n = ~ctl_q[SPP_CT_STROBE];
    assign line_feed_n = ~ctl_q[SPP_CT_LFEED];
    assign printer_init_n = ctl_q[SPP_CT_INIT];
    assign select_in_n = ~ctl_q[SPP_CT_SELIN];
    assign port_irq = irq_q;
    assign port_irq_oe_n = irq_oe_n_q;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_status_rd;
        rd_start && host_addr == SPP_OFS_STATUS;
    endsequence
    sequence s_data_wr;
        wr_start && host_addr == SPP_OFS_DATA;
    endsequence
    sequence s_ctl_wr;
        wr_start && host_addr == SPP_OFS_CONTROL;
    endsequence

    tout_rd_clear_a: assert property (s_status_rd ##0 !tout_evt_q ##0 is_epp(port_mode)
        ##0 is_epp(mode_q) |=> !tout_q) else $error("time-out flag not read-cleared");
    tout_set_a: assert property (tout_evt_q && is_epp(port_mode) |=> tout_q)
        else $error("time-out flag not set");
    // a pulse may only follow a full count of stalled cycles
    tout_count_a: assert property (tout_evt_q |->
        $past(tcnt_q) == SPP_TOUT_W'(SPP_TOUT_CYC - 1) && $past(epp_cycle_stalled))
        else $error("time-out fired early");
    stat_const_a: assert property (s_status_rd ##0 !is_epp(port_mode)
        |=> rdata_q[1:0] == 2'h3) else $error("status bits 1..0 not one");
    ack_latch_a: assert property (port_mode == SPP_MODE_EXT && ctl_q[SPP_CT_IEN]
        && ack_rise |=> !irq_stat_n_q) else $error("ack edge not latched");
    data_wr_a: assert property (s_data_wr |=> data_q == $past(host_wdata))
        else $error("data latch not written");
    dir_in_a: assert property (port_mode == SPP_MODE_EXT && ctl_q[SPP_CT_DIR]
        |=> printer_data_lines_oe_n) else $error("lines driven in input direction");
    stat_wr_a: assert property (wr_start && host_addr == SPP_OFS_STATUS
        |=> $stable(data_q) && $stable(ctl_q)) else $error("status write changed state");
    strobe_pin_a: assert property (s_ctl_wr |=> printer_strobe_n == !$past(host_wdata[0]))
        else $error("strobe pin wrong polarity");
    ctl_hi_a: assert property (rd_start && host_addr == SPP_OFS_CONTROL
        |=> rdata_q[7:6] == 2'h3) else $error("control bits 7..6 not one");
    off3_a: assert property (!host_rd_n && host_addr == SPP_OFS_NONE
        |=> host_rdata_oe_n) else $error("offset 3 drove host bus");
    irq_float_a: assert property (!ctl_q[SPP_CT_IEN] |=> port_irq_oe_n)
        else $error("irq driven while disabled");

endmodule // spp_parallel_port_registers
`default_nettype wire

// File: spp_parallel_port_registers_test.sv
`timescale 1ns/100ps
`default_nettype none
module spp_parallel_port_registers_test
    import spp_pkg::*;
;
    logic mclk, reset, host_rd_n, host_wr_n, host_rdata_oe_n, epp_cycle_stalled;
    logic [1:0] port_mode, host_addr;
    logic [7:0] host_wdata, host_rdata, periph_byte, lines_out, lines_in, rd;
    logic epp_timeout_abort, lines_oe_n, strobe_n, lf_n, init_n, selin_n, force_strobe_low;
    logic [3:0] hs_in;
    logic fault_n, selected, paper, ack_n, not_ready, port_irq, port_irq_oe_n;
    int n_mismatch, total_checks, i;

    spp_parallel_port_registers dut (.mclk(mclk), .reset(reset), .port_mode(port_mode),
        .host_addr(host_addr), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_oe_n(host_rdata_oe_n),
        .epp_cycle_stalled(epp_cycle_stalled), .epp_timeout_abort(epp_timeout_abort),
        .printer_data_lines_in(lines_in), .printer_data_lines_out(lines_out),
        .printer_data_lines_oe_n(lines_oe_n), .printer_strobe_n(strobe_n),
        .line_feed_n(lf_n), .printer_init_n(init_n), .select_in_n(selin_n),
        .printer_strobe_n_in(hs_in[0]), .line_feed_n_in(hs_in[1]),
        .printer_init_n_in(hs_in[2]), .select_in_n_in(hs_in[3]),
        .printer_fault_n(fault_n), .printer_selected(selected), .paper_out(paper),
        .printer_ack_n(ack_n), .printer_not_ready_pin(not_ready),
        .port_irq(port_irq), .port_irq_oe_n(port_irq_oe_n));

    spp_printer_model printer (.lines_out(lines_out), .lines_oe_n(lines_oe_n),
        .periph_byte(periph_byte), .lines_in(lines_in),
        .hs_out({selin_n, init_n, lf_n, strobe_n}),
        .force_strobe_low(force_strobe_low), .hs_in(hs_in));

    // free-running system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // strobe low for one taking edge, then one high cycle before the next access
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge mclk);
        host_addr = a;
        host_wdata = d;
        host_wr_n = 1'b0;
        @(negedge mclk);
        host_wr_n = 1'b1;
        @(negedge mclk);
    endtask

    // data is looked at a cycle and a half after the taking edge, strobe still low
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(negedge mclk);
        host_addr = a;
        host_rd_n = 1'b0;
        repeat (2) @(negedge mclk);
        d = host_rdata;
        check("bus drive", {7'h0, a == SPP_OFS_NONE}, {7'h0, host_rdata_oe_n});
        host_rd_n = 1'b1;
        @(negedge mclk);
    endtask

    function automatic logic [7:0] st(input logic t0, input logic t2);
        return {~not_ready, ack_n, paper, selected, fault_n, t2, 1'b1, t0};
    endfunction

    task automatic t_reset();
        rd_reg(SPP_OFS_DATA, rd);
        check("data reset", 8'h00, rd);
        rd_reg(SPP_OFS_CONTROL, rd);
        check("control reset", 8'he4, rd);
        check("pins reset", 8'h0f, {4'h0, selin_n, init_n, lf_n, strobe_n});
        check("irq float", 8'h01, {7'h0, port_irq_oe_n});
    endtask

    task automatic t_compat();
        port_mode = SPP_MODE_COMPAT;
        wr(SPP_OFS_CONTROL, 8'h2b);
        check("pins set", 8'h00, {4'h0, selin_n, init_n, lf_n, strobe_n});
        rd_reg(SPP_OFS_CONTROL, rd);
        check("control read", 8'heb, rd);
        wr(SPP_OFS_DATA, 8'ha5);
        check("lines out", 8'ha5, lines_out);
        check("lines drive", 8'h00, {7'h0, lines_oe_n});
        rd_reg(SPP_OFS_DATA, rd);
        check("latch read", 8'ha5, rd);
        wr(SPP_OFS_CONTROL, 8'h04);
    endtask

    task automatic t_ext();
        port_mode = SPP_MODE_EXT;
        wr(SPP_OFS_CONTROL, 8'h24);
        wr(SPP_OFS_DATA, 8'h3c);
        check("lines released", 8'h01, {7'h0, lines_oe_n});
        rd_reg(SPP_OFS_DATA, rd);
        check("line read", 8'h5a, rd);
        rd_reg(SPP_OFS_CONTROL, rd);
        check("dir reads one", 8'he4, rd);
        wr(SPP_OFS_CONTROL, 8'h04);
        check("lines driven", 8'h3c, lines_oe_n ? 8'hff : lines_out);
        rd_reg(SPP_OFS_DATA, rd);
        check("ext latch read", 8'h3c, rd);
        ack_n = 1'b0;
        @(negedge mclk);
        ack_n = 1'b1;
        rd_reg(SPP_OFS_STATUS, rd);
        check("no latch when off", st(1'b1, 1'b1), rd);
    endtask

    task automatic t_status();
        port_mode = SPP_MODE_COMPAT;
        {fault_n, selected, paper, not_ready} = 4'h7;
        rd_reg(SPP_OFS_STATUS, rd);
        check("status a", st(1'b1, 1'b1), rd);
        {fault_n, selected, paper, ack_n, not_ready} = 5'h10;
        rd_reg(SPP_OFS_STATUS, rd);
        check("status b", st(1'b1, 1'b1), rd);
        ack_n = 1'b1;
        wr(SPP_OFS_STATUS, 8'h00);
        wr(SPP_OFS_NONE, 8'h00);
        rd_reg(SPP_OFS_DATA, rd);
        check("data kept", 8'h3c, rd);
        rd_reg(SPP_OFS_CONTROL, rd);
        check("control kept", 8'he4, rd);
        rd_reg(SPP_OFS_NONE, rd);
        force_strobe_low = 1'b1;
        rd_reg(SPP_OFS_CONTROL, rd);
        check("strobe sensed", 8'he5, rd);
        force_strobe_low = 1'b0;
    endtask

    task automatic t_ext_irq();
        port_mode = SPP_MODE_COMPAT;
        wr(SPP_OFS_CONTROL, 8'h14);
        check("compat irq high", 8'h01, {6'h0, port_irq_oe_n, port_irq});
        ack_n = 1'b0;
        repeat (2) @(negedge mclk);
        check("compat irq low", 8'h00, {6'h0, port_irq_oe_n, port_irq});
        port_mode = SPP_MODE_EXT;
        @(negedge mclk);
        ack_n = 1'b1;
        repeat (3) @(negedge mclk);
        check("irq raised", 8'h01, {6'h0, port_irq_oe_n, port_irq});
        rd_reg(SPP_OFS_STATUS, rd);
        check("irq status", st(1'b1, 1'b0), rd);
        rd_reg(SPP_OFS_STATUS, rd);
        check("irq restored", st(1'b1, 1'b1), rd);
        check("irq cleared", 8'h00, {6'h0, port_irq_oe_n, port_irq});
    endtask

    // ack held low so the time-out pulse stands out on the irq line
    task automatic t_epp();
        wr(SPP_OFS_CONTROL, 8'h14);
        port_mode = SPP_MODE_EPP;
        ack_n = 1'b0;
        repeat (2) @(negedge mclk);
        rd_reg(SPP_OFS_STATUS, rd);
        check("epp entry", st(1'b0, 1'b1), rd);
        check("epp irq ack", 8'h00, {6'h0, port_irq_oe_n, port_irq});
        epp_cycle_stalled = 1'b1;
        for (i = 0; i < 1100 && epp_timeout_abort !== 1'b1; i++) @(negedge mclk);
        check("abort delay", 8'h01, {7'h0, i == SPP_TOUT_CYC});
        epp_cycle_stalled = 1'b0;
        @(negedge mclk);
        check("epp irq pulse", 8'h01, {6'h0, port_irq_oe_n, port_irq});
        @(negedge mclk);
        check("epp irq end", 8'h00, {6'h0, port_irq_oe_n, port_irq});
        ack_n = 1'b1;
        rd_reg(SPP_OFS_STATUS, rd);
        check("time-out set", st(1'b1, 1'b1), rd);
        rd_reg(SPP_OFS_STATUS, rd);
        check("time-out read", st(1'b0, 1'b1), rd);
        check("epp irq follows", 8'h01, {6'h0, port_irq_oe_n, port_irq});
        rd_reg(SPP_OFS_CONTROL, rd);
        check("epp dir read", 8'hd4, rd);
        wr(SPP_OFS_CONTROL, 8'h34);
        rd_reg(SPP_OFS_CONTROL, rd);
        check("epp dir set", 8'hf4, rd);
        check("epp lines drive", 8'h00, {7'h0, lines_oe_n});
    endtask

    // enable cleared before the mode change, as software must for ecp
    task automatic t_other();
        wr(SPP_OFS_CONTROL, 8'h04);
        port_mode = SPP_MODE_OTHER;
        rd_reg(SPP_OFS_STATUS, rd);
        check("other status", st(1'b1, 1'b1), rd);
        rd_reg(SPP_OFS_CONTROL, rd);
        check("other control", 8'he4, rd);
        check("other irq float", 8'h01, {7'h0, port_irq_oe_n});
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // main sequence; all inputs settle at time zero
    initial begin
        {reset, host_rd_n, host_wr_n, ack_n} = 4'hf;
        {port_mode, host_addr, host_wdata} = 12'h0;
        {epp_cycle_stalled, force_strobe_low, fault_n, selected, paper, not_ready} = 6'h0c;
        periph_byte = 8'h5a;
        repeat (6) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        t_reset();
        t_compat();
        t_ext();
        t_status();
        t_ext_irq();
        t_epp();
        t_other();
        complete_run();
    end

    // a hang costs far more than the little over a thousand cycles the tests need
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule // spp_parallel_port_registers_test
`default_nettype wire

// File: spp_pkg.sv
package spp_pkg;
    // host register offsets
    localparam logic [1:0] SPP_OFS_DATA = 2'h0;
    localparam logic [1:0] SPP_OFS_STATUS = 2'h1;
    localparam logic [1:0] SPP_OFS_CONTROL = 2'h2;
    localparam logic [1:0] SPP_OFS_NONE = 2'h3;
    // port modes delivered by the configuration logic
    localparam logic [1:0] SPP_MODE_COMPAT = 2'h0;
    localparam logic [1:0] SPP_MODE_EXT = 2'h1;
    localparam logic [1:0] SPP_MODE_EPP = 2'h2;
    localparam logic [1:0] SPP_MODE_OTHER = 2'h3;
    // status bit positions
    localparam int SPP_ST_TOUT = 0;
    localparam int SPP_ST_RSVD = 1;
    localparam int SPP_ST_IRQ = 2;
    localparam int SPP_ST_FAULT = 3;
    localparam int SPP_ST_SEL = 4;
    localparam int SPP_ST_PAPER = 5;
    localparam int SPP_ST_ACK = 6;
    localparam int SPP_ST_READY = 7;
    // control bit positions
    localparam int SPP_CT_STROBE = 0;
    localparam int SPP_CT_LFEED = 1;
    localparam int SPP_CT_INIT = 2;
    localparam int SPP_CT_SELIN = 3;
    localparam int SPP_CT_IEN = 4;
    localparam int SPP_CT_DIR = 5;
    // reset values
    localparam logic [7:0] SPP_DATA_RST = 8'h00;
    localparam logic [5:0] SPP_CTL_RST = 6'h04;
    localparam logic [1:0] SPP_CTL_HI_BITS = 2'h3;
    // epp time-out: least time, rounded up to whole clock cycles
    localparam int SPP_CLK_PERIOD_NS = 10;
    localparam int SPP_TOUT_US = 10;
    localparam int SPP_TOUT_CYC =
        (SPP_TOUT_US * 1000 + SPP_CLK_PERIOD_NS - 1) / SPP_CLK_PERIOD_NS;
    localparam int SPP_TOUT_W = 11;
endpackage

// File: spp_printer_model.sv
`timescale 1ns/100ps
`default_nettype none
module spp_printer_model (
    // data lines as seen on the connector
    input wire logic [7:0] lines_out,
    input wire logic lines_oe_n,
    input wire logic [7:0] periph_byte,
    output logic [7:0] lines_in,
    // handshake pins: port drive in, sensed level out
    input wire logic [3:0] hs_out,
    input wire logic force_strobe_low,
    output logic [3:0] hs_in
);
    // the peripheral drives only while the port has let go of the lines
    assign lines_in = lines_oe_n ? periph_byte : lines_out;
    // an outside low on the strobe pin beats the port's inactive high
    assign hs_in = {hs_out[3:1], hs_out[0] & ~force_strobe_low};
endmodule // spp_printer_model
`default_nettype wire
